/* File: sfpp_ans_if.sv */
/*
 * Carrier between the interpreter and its answer sender.
 * Assumes both ends sit on the same clock.
 */
interface sfpp_ans_if;
    logic       send;   // One-cycle request to send a byte.
    logic [7:0] data;   // Byte to send, valid with send.
    logic       busy;   // Sender holds an unsent byte.

    modport src (output send, output data, input busy);
    modport snk (input send, input data, output busy);
endinterface

/* File: sfpp_core.sv */
/*
 * Boot-link command interpreter: chip erase closing bytes, flash
 * program command with header and data checksums, protect-set entry.
 * Assumes an on-clock byte receiver that flags receive errors, an
 * on-clock flash controller, and a controller that waits for each
 * answer before sending the next byte.
 */
// Function
// [R1] Confirm 5Dh or 60h after result
// [R2] Result 4Fh success, 4Ch failure
// [R3] 50h requests programming
// [R4] Errored command answers x8h
// [R5] Error upper nibble from command
// [R6] Program needs no protection, prior erase
// [R7] Protection answers x6h
// [R8] No prior erase answers x4h
// [R9] Unknown command answers x1h
// [R10] Address MSB first
// [R11] Count high byte first
// [R12] Header checksum is negated sum
// [R13] Even address in range, count 1..400h; code checks neither address nor count
// [R14] Erase before reprogramming; code never clears the erased flag after programming
// [R15] Header receive error answers 58h
// [R16] Header sum nonzero answers 51h
// [R17] Clean block answers 50h
// [R18] Data written sequentially from start
// [R19] Data checksum follows data
// [R20] Data block: 58h, 51h, else 50h
// [R21] Next command after answer
// [R22] Clean 60h echoes, enters protect-set
// [R23] Protect-set checks password area
// [R24] Bit 3 receive error, bit 0 other
// [R25] After error, next byte is command
module sfpp_core
    import sfpp_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // Receive stream
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_err,
    // Transmit stream
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_data,
    input  wire logic        i_tx_ready,
    // Protection status
    input  wire logic        i_read_prot,
    input  wire logic        i_write_prot,
    // Chip erase engine
    output logic             o_erase_start,
    input  wire logic        i_erase_done,
    input  wire logic        i_erase_fail,
    // Flash byte write port
    output logic             o_fl_wr,
    output logic [31:0]      o_fl_addr,
    output logic [7:0]       o_fl_data,
    // Other routines
    output logic             o_pw_check,
    input  wire logic        i_pset_done,
    output logic             o_other_cmd,
    output logic [7:0]       o_other_code
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Error answer: upper nibble from the latest command byte.
    function automatic logic [7:0] err_ans(input logic [7:0] cmd,
                                           input logic [3:0] nib);
        return {cmd[7:4], nib}; // [R5] [R24]
    endfunction

    // Eight-bit running sum, carries dropped.
    function automatic logic [7:0] add8(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0];
    endfunction

    function automatic logic known_cmd(input logic [7:0] c);
        return (c[3:0] == 4'h0) && (c >= SFPP_CMD_RAM) && (c <= SFPP_CMD_PROTSET);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sfpp_state_t state_r, state_nxt;
    logic [7:0]  last_cmd_r, last_cmd_nxt;
    logic        erased_r, erased_nxt;
    logic [2:0]  hidx_r, hidx_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0]  sum_r, sum_nxt;
    logic        rxe_r, rxe_nxt;
    logic        erase_start_r, erase_start_nxt;
    logic        fl_wr_r, fl_wr_nxt;
    logic [31:0] fl_addr_r, fl_addr_nxt;
    logic [7:0]  fl_data_r, fl_data_nxt;
    logic        pw_check_r, pw_check_nxt;
    logic        other_r, other_nxt;
    logic [7:0]  other_code_r, other_code_nxt;
    logic        send;
    logic [7:0]  send_data;
    logic [7:0]  sum_in;
    logic        rxe_in;

    sfpp_ans_if ans ();

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Answers to received bytes are sent without waiting on the sender:
    // the controller waits for each answer, so the slot is free again.
    always_comb begin
        state_nxt       = state_r;
        last_cmd_nxt    = last_cmd_r;
        erased_nxt      = erased_r;
        hidx_nxt        = hidx_r;
        addr_nxt        = addr_r;
        cnt_nxt         = cnt_r;
        sum_nxt         = sum_r;
        rxe_nxt         = rxe_r;
        erase_start_nxt = 1'b0;
        fl_wr_nxt       = 1'b0;
        fl_addr_nxt     = fl_addr_r;
        fl_data_nxt     = fl_data_r;
        pw_check_nxt    = 1'b0;
        other_nxt       = 1'b0;
        other_code_nxt  = other_code_r;
        send            = 1'b0;
        send_data       = SFPP_BYTE_RST;
        sum_in          = add8(sum_r, i_rx_data);
        rxe_in          = rxe_r || i_rx_err;
        unique case (state_r)
            SFPP_S_CMD: begin
                if (i_rx_valid) begin
                    last_cmd_nxt = i_rx_data;
                    send         = 1'b1;
                    hidx_nxt     = 3'h0;
                    sum_nxt      = SFPP_SUM_ZERO;
                    rxe_nxt      = 1'b0;
                    if (i_rx_err) begin
                        send_data = err_ans(i_rx_data, SFPP_NIB_RXERR); // [R4]
                    end else if (!known_cmd(i_rx_data)) begin
                        send_data = err_ans(i_rx_data, SFPP_NIB_BADCMD); // [R9]
                    end else if (i_rx_data == SFPP_CMD_PROG) begin // [R3]
                        if (i_read_prot || i_write_prot) begin
                            send_data = err_ans(i_rx_data, SFPP_NIB_PROT); // [R7]
                        end else if (!erased_r) begin
                            send_data = err_ans(i_rx_data, SFPP_NIB_NOERASE); // [R8]
                        end else begin
                            send_data = SFPP_CMD_PROG; // [R6]
                            state_nxt = SFPP_S_HDR;
                        end
                    end else if (i_rx_data == SFPP_CMD_ERASE) begin
                        send_data = SFPP_CMD_ERASE;
                        state_nxt = SFPP_S_EKEY;
                    end else if (i_rx_data == SFPP_CMD_PROTSET) begin
                        send_data    = SFPP_CMD_PROTSET; // [R22]
                        pw_check_nxt = 1'b1; // [R23]
                        state_nxt    = SFPP_S_PSET;
                    end else begin
                        // Other routines are run elsewhere; only the echo is here.
                        send_data      = i_rx_data;
                        other_nxt      = 1'b1;
                        other_code_nxt = i_rx_data;
                    end
                end
            end
            SFPP_S_EKEY: begin
                if (i_rx_valid) begin
                    send = 1'b1;
                    if (i_rx_err) begin
                        send_data = err_ans(last_cmd_r, SFPP_NIB_RXERR);
                        state_nxt = SFPP_S_CMD; // [R25]
                    end else if (i_rx_data != SFPP_ERASE_KEY) begin
                        send_data = err_ans(last_cmd_r, SFPP_NIB_BADCMD);
                        state_nxt = SFPP_S_CMD; // [R25]
                    end else begin
                        send_data       = SFPP_ERASE_KEY;
                        erase_start_nxt = 1'b1;
                        state_nxt       = SFPP_S_EWAIT;
                    end
                end
            end
            SFPP_S_EWAIT: begin
                if (i_erase_done && !ans.busy) begin
                    send       = 1'b1;
                    erased_nxt = !i_erase_fail;
                    send_data  = i_erase_fail ? SFPP_ANS_ERASE_FAIL
                                              : SFPP_ANS_ERASE_OK; // [R2]
                    state_nxt  = SFPP_S_ECONF;
                end
            end
            SFPP_S_ECONF: begin
                // Waits for the result byte to leave before confirming.
                if (!ans.busy) begin
                    send      = 1'b1;
                    send_data = erased_r ? SFPP_ANS_CONF_OK
                                         : SFPP_ANS_CONF_FAIL; // [R1]
                    state_nxt = SFPP_S_CMD;
                end
            end
            SFPP_S_HDR: begin
                if (i_rx_valid) begin
                    sum_nxt  = sum_in;
                    rxe_nxt  = rxe_in;
                    hidx_nxt = hidx_r + 3'h1;
                    if (hidx_r < 3'h4) begin
                        addr_nxt = {addr_r[23:0], i_rx_data}; // [R10]
                    end else if (hidx_r < SFPP_HDR_LAST) begin
                        cnt_nxt = {cnt_r[7:0], i_rx_data}; // [R11]
                    end else begin
                        send = 1'b1;
                        if (rxe_in) begin
                            send_data = err_ans(last_cmd_r, SFPP_NIB_RXERR); // [R15]
                            state_nxt = SFPP_S_CMD; // [R25]
                        end else if (sum_in != SFPP_SUM_ZERO) begin
                            send_data = SFPP_ANS_PROG_SUM; // [R16] [R12]
                            state_nxt = SFPP_S_CMD; // [R25]
                        end else begin
                            send_data = SFPP_ANS_PROG_OK; // [R17]
                            sum_nxt   = SFPP_SUM_ZERO;
                            rxe_nxt   = 1'b0;
                            state_nxt = (cnt_r == SFPP_CNT_RST) ? SFPP_S_DSUM
                                                                : SFPP_S_DATA;
                        end
                    end
                end
            end
            SFPP_S_DATA: begin
                if (i_rx_valid) begin
                    sum_nxt = sum_in;
                    rxe_nxt = rxe_in;
                    cnt_nxt = cnt_r - 16'h0001;
                    addr_nxt = addr_r + 32'h0000_0001;
                    // Bytes with a receive error are not written.
                    fl_wr_nxt   = !i_rx_err; // [R18]
                    fl_addr_nxt = addr_r;
                    fl_data_nxt = i_rx_data;
                    if (cnt_r == 16'h0001) begin
                        state_nxt = SFPP_S_DSUM; // [R19]
                    end
                end
            end
            SFPP_S_DSUM: begin
                if (i_rx_valid) begin
                    send      = 1'b1;
                    state_nxt = SFPP_S_CMD; // [R21]
                    if (rxe_in) begin
                        send_data = err_ans(last_cmd_r, SFPP_NIB_RXERR); // [R20]
                    end else if (sum_in != SFPP_SUM_ZERO) begin
                        send_data = SFPP_ANS_PROG_SUM; // [R20]
                    end else begin
                        send_data = SFPP_ANS_PROG_OK; // [R20]
                    end
                end
            end
            SFPP_S_PSET: begin
                if (i_pset_done) begin
                    state_nxt = SFPP_S_CMD;
                end
            end
            default: begin
                state_nxt = SFPP_S_CMD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r       <= SFPP_S_CMD;
            last_cmd_r    <= SFPP_BYTE_RST;
            erased_r      <= 1'b0;
            hidx_r        <= 3'h0;
            addr_r        <= SFPP_ADDR_RST;
            cnt_r         <= SFPP_CNT_RST;
            sum_r         <= SFPP_SUM_ZERO;
            rxe_r         <= 1'b0;
            erase_start_r <= 1'b0;
            fl_wr_r       <= 1'b0;
            fl_addr_r     <= SFPP_ADDR_RST;
            fl_data_r     <= SFPP_BYTE_RST;
            pw_check_r    <= 1'b0;
            other_r       <= 1'b0;
            other_code_r  <= SFPP_BYTE_RST;
        end else begin
            state_r       <= state_nxt;
            last_cmd_r    <= last_cmd_nxt;
            erased_r      <= erased_nxt;
            hidx_r        <= hidx_nxt;
            addr_r        <= addr_nxt;
            cnt_r         <= cnt_nxt;
            sum_r         <= sum_nxt;
            rxe_r         <= rxe_nxt;
            erase_start_r <= erase_start_nxt;
            fl_wr_r       <= fl_wr_nxt;
            fl_addr_r     <= fl_addr_nxt;
            fl_data_r     <= fl_data_nxt;
            pw_check_r    <= pw_check_nxt;
            other_r       <= other_nxt;
            other_code_r  <= other_code_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Answer sender and outputs
    // ------------------------------------------------------------------
    assign ans.send = send;
    assign ans.data = send_data;

    sfpp_tx u_tx (
        .i_sys_clk  (i_sys_clk),
        .i_reset_n  (i_reset_n),
        .ans        (ans),
        .o_tx_valid (o_tx_valid),
        .o_tx_data  (o_tx_data),
        .i_tx_ready (i_tx_ready)
    );

    assign o_erase_start = erase_start_r;
    assign o_fl_wr       = fl_wr_r;
    assign o_fl_addr     = fl_addr_r;
    assign o_fl_data     = fl_data_r;
    assign o_pw_check    = pw_check_r;
    assign o_other_cmd   = other_r;
    assign o_other_code  = other_code_r;

endmodule // sfpp_core

/* File: sfpp_core_chk.sv */
/*
 * Concurrent checks on the interpreter ports, bound to its top.
 * Assumes one clock and an asynchronous active-low reset.
 */
module sfpp_core_chk
    import sfpp_pkg::*;
(
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    // Streams
    input wire logic        i_rx_valid,
    input wire logic [7:0]  i_rx_data,
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_data,
    input wire logic        i_tx_ready,
    // Side outputs and receive error flag
    input wire logic        o_erase_start,
    input wire logic        o_fl_wr,
    input wire logic [31:0] o_fl_addr,
    input wire logic [7:0]  o_fl_data,
    input wire logic        o_pw_check,
    input wire logic        i_rx_err
);
    logic [7:0]  last_r;
    logic        wseen_r;
    logic [31:0] waddr_r;
    logic        key_in, pw_in;

    // Key bytes seen on the receive side.
    assign key_in = i_rx_valid && i_rx_data == SFPP_ERASE_KEY;
    assign pw_in  = i_rx_valid && i_rx_data == SFPP_CMD_PROTSET;

    // Last taken answer; any answer ends a run of sequential writes.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_r  <= 8'h00;
            wseen_r <= 1'b0;
            waddr_r <= 32'h0000_0000;
        end else begin
            if (o_tx_valid && i_tx_ready) last_r <= o_tx_data;
            wseen_r <= o_fl_wr || (wseen_r && !o_tx_valid);
            if (o_fl_wr) waddr_r <= o_fl_addr;
        end
    end

    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_took(logic [7:0] b);
        o_tx_valid && i_tx_ready && o_tx_data == b;
    endsequence
    property p_stand;
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    a_stand: assert property (p_stand) else $error("answer lost while stalled");
    property p_conf_ok;
        s_took(SFPP_ANS_ERASE_OK) |-> ##[1:40] (o_tx_valid && o_tx_data == SFPP_ANS_CONF_OK);
    endproperty
    a_conf_ok: assert property (p_conf_ok) else $error("no erase confirmation");
    property p_conf_fail;
        s_took(SFPP_ANS_ERASE_FAIL) |-> ##[1:40] (o_tx_valid && o_tx_data == SFPP_ANS_CONF_FAIL);
    endproperty
    a_conf_fail: assert property (p_conf_fail) else $error("no erase error confirmation");
    property p_conf_first;
        o_tx_valid && (last_r == SFPP_ANS_ERASE_OK || last_r == SFPP_ANS_ERASE_FAIL) |->
            o_tx_data == (last_r == SFPP_ANS_ERASE_OK ? SFPP_ANS_CONF_OK : SFPP_ANS_CONF_FAIL);
    endproperty
    a_conf_first: assert property (p_conf_first) else $error("wrong byte after result");
    property p_erase_key;
        o_erase_start |-> $past(key_in) || $past(key_in, 2) || $past(key_in, 3);
    endproperty
    a_erase_key: assert property (p_erase_key) else $error("erase without key");
    property p_pw_key;
        o_pw_check |-> ($past(pw_in) || $past(pw_in, 2) || $past(pw_in, 3)) ##1 !o_pw_check;
    endproperty
    a_pw_key: assert property (p_pw_key) else $error("password check misplaced");
    property p_wr_data;
        o_fl_wr |-> $past(i_rx_valid) && !$past(i_rx_err) && o_fl_data == $past(i_rx_data);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data mismatch");
    property p_wr_seq;
        o_fl_wr && wseen_r |-> o_fl_addr == waddr_r + 32'h1;
    endproperty
    a_wr_seq: assert property (p_wr_seq) else $error("write address not sequential");
endmodule // sfpp_core_chk

bind sfpp_core sfpp_core_chk u_chk (.*);

/* File: sfpp_core_tb_top.sv */
/*
 * Self-checking bench with controller model and erase stub.
 * Assumes the interpreter's answer timing and erase handshake.
 */
module sfpp_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_sys_clk, i_reset_n, i_rx_valid, i_rx_err, i_tx_ready, o_tx_valid;
    logic [7:0]  i_rx_data, o_tx_data, o_fl_data, o_other_code, r;
    logic        i_read_prot, i_write_prot, o_erase_start, i_erase_done, i_erase_fail;
    logic        o_fl_wr, o_pw_check, i_pset_done, o_other_cmd;
    logic [31:0] o_fl_addr, wq [$];
    int          errors = 0, checked = 0, seed = 4009, pw_cnt = 0;
    logic [7:0]  bad_cmds [5] = '{8'h00, 8'h70, 8'ha5, 8'hff, 8'h41};
    logic [7:0]  oth_cmds [3] = '{8'h10, 8'h20, 8'h30};

    sfpp_core dut (.*);
    sfpp_ctl_model ctl (.i_sys_clk, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
        .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
        .o_rx_err(i_rx_err));

    // 10 MHz clock.
    always #50 i_sys_clk = ~i_sys_clk;

    // Record flash writes and password checks as they are sampled.
    always @(posedge i_sys_clk) begin
        if (o_fl_wr) wq.push_back({o_fl_addr[23:0], o_fl_data});
        if (o_pw_check) pw_cnt++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A missing answer reads as unknown, so the comparison fails.
    task automatic get_ans(output logic [7:0] a);
        int n;
        n = 0;
        while (ctl.ans_q.size() == 0 && n < 200) begin
            @(negedge i_sys_clk);
            n++;
        end
        a = (ctl.ans_q.size() == 0) ? 8'hxx : ctl.ans_q.pop_front();
    endtask

    task automatic cmd(input logic [7:0] b, input logic e, input logic [7:0] exp);
        logic [7:0] a;
        ctl.send(b, e);
        get_ans(a);
        chk(a, exp);
    endtask

    // The done level is held until the result arrives, so it cannot be missed.
    task automatic erase(input logic fail);
        logic [7:0] a;
        cmd(8'h40, 1'b0, 8'h40);
        cmd(8'h54, 1'b0, 8'h54);
        i_erase_done = 1'b1;
        i_erase_fail = fail;
        get_ans(a);
        chk(a, fail ? 8'h4c : 8'h4f);
        i_erase_done = 1'b0;
        get_ans(a);
        chk(a, fail ? 8'h60 : 8'h5d);
    endtask

    // Fault: 0 none, 1 header sum, 2 header receive, 3 data sum, 4 data receive.
    task automatic prog(input logic [31:0] a, input logic [15:0] n, input int f);
        logic [7:0] h [7];
        logic [7:0] d [$];
        logic [7:0] s, ans;
        erase(1'b0);
        cmd(8'h50, 1'b0, 8'h50);
        h = '{a[31:24], a[23:16], a[15:8], a[7:0], n[15:8], n[7:0], 8'h00};
        s = 8'h00;
        for (int k = 0; k < 6; k++) s += h[k];
        h[6] = 8'h00 - s + {7'h0, f == 1};
        for (int k = 0; k < 7; k++) ctl.send(h[k], f == 2 && k == 3);
        get_ans(ans);
        chk(ans, f == 1 ? 8'h51 : (f == 2 ? 8'h58 : 8'h50));
        if (f == 1 || f == 2) return;
        wq.delete();
        s = 8'h00;
        for (int k = 0; k < n; k++) begin
            d.push_back(8'($random(seed)));
            s += d[k];
            ctl.send(d[k], f == 4 && k == 0);
        end
        ctl.send(8'h00 - s + {7'h0, f == 3}, 1'b0);
        get_ans(ans);
        chk(ans, f == 3 ? 8'h51 : (f == 4 ? 8'h58 : 8'h50));
        chk(32'(wq.size()), f == 4 ? n - 16'h1 : n);
        if (f != 4) foreach (d[k]) chk(wq[k], {a[23:0] + 24'(k), d[k]});
    endtask

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Cut a hang well past the expected run length.
    initial begin
        #5_000_000;
        errors++;
        conclude();
    end

    initial begin
        i_sys_clk = 1'b0;
        i_reset_n = 1'b0;
        {i_read_prot, i_write_prot, i_erase_done, i_erase_fail, i_pset_done} = 5'h00;
        repeat (10) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        cmd(8'h50, 1'b0, 8'h54);
        foreach (bad_cmds[i]) cmd(bad_cmds[i], 1'b0, {bad_cmds[i][7:4], 4'h1});
        r = 8'($random(seed));
        cmd({r[7:4], r[3:0] | 4'h1}, 1'b0, {r[7:4], 4'h1});
        cmd({r[7:4], 4'h0}, 1'b1, {r[7:4], 4'h8});
        foreach (oth_cmds[i]) cmd(oth_cmds[i], 1'b0, oth_cmds[i]);
        $display("command error test done");
        erase(1'b1);
        cmd(8'h50, 1'b0, 8'h54);
        erase(1'b0);
        i_read_prot = 1'b1;
        cmd(8'h50, 1'b0, 8'h56);
        {i_read_prot, i_write_prot} = 2'b01;
        cmd(8'h50, 1'b0, 8'h56);
        i_write_prot = 1'b0;
        $display("erase and protection test done");
        prog(32'h0004_fc00, 16'h0400, 0);
        repeat (3) prog(32'h0001_0000 + (32'($random(seed)) & 32'h0003_fffe),
            16'(1 + ($random(seed) & 7)), 0);
        for (int f = 1; f < 5; f++) prog(32'h0002_0000, 16'h0005, f);
        $display("program test done");
        cmd(8'h60, 1'b0, 8'h60);
        repeat (2) @(negedge i_sys_clk);
        chk(pw_cnt, 1);
        i_pset_done = 1'b1;
        @(negedge i_sys_clk);
        i_pset_done = 1'b0;
        cmd(8'h70, 1'b0, 8'h71);
        $display("protect set test done");
        conclude();
    end
endmodule // sfpp_core_tb_top

/* File: sfpp_ctl_model.sv */
/*
 * Behavioural programming controller on the far side of the boot link.
 * Assumes the bench calls send and reads ans_q; all on one clock.
 */
module sfpp_ctl_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Answers from the device
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    // Bytes to the device
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_err
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] ans_q [$];
    logic [1:0] stall_r = 2'h0;

    // Idle line at time zero.
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_rx_err   = 1'b0;
        o_tx_ready = 1'b0;
    end

    // Refuse one cycle in four so answers must stand while stalled.
    always @(negedge i_sys_clk) begin
        stall_r    <= stall_r + 2'h1;
        o_tx_ready <= (stall_r != 2'h3);
    end

    // Collect every answer taken.
    always @(posedge i_sys_clk) begin
        if (i_tx_valid && o_tx_ready) ans_q.push_back(i_tx_data);
    end

    // One byte; the released data line shows the inverse, not a stale value.
    task automatic send(input logic [7:0] b, input logic e);
        @(negedge i_sys_clk);
        o_rx_valid = 1'b1;
        o_rx_data  = b;
        o_rx_err   = e;
        @(negedge i_sys_clk);
        o_rx_valid = 1'b0;
        o_rx_data  = ~b;
        o_rx_err   = 1'b0;
    endtask
endmodule // sfpp_ctl_model

/* File: sfpp_pkg.sv */
/*
 * Command codes, answer codes and header layout of the interpreter.
 * Assumes a byte-wide receive stream and one clock domain.
 */
package sfpp_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] SFPP_CMD_RAM     = 8'h10;
    localparam logic [7:0] SFPP_CMD_SUM     = 8'h20;
    localparam logic [7:0] SFPP_CMD_INFO    = 8'h30;
    localparam logic [7:0] SFPP_CMD_ERASE   = 8'h40;
    localparam logic [7:0] SFPP_CMD_PROG    = 8'h50;
    localparam logic [7:0] SFPP_CMD_PROTSET = 8'h60;
    localparam logic [7:0] SFPP_ERASE_KEY   = 8'h54;

    // ------------------------------------------------------------------
    // Answer codes and low nibbles of error answers
    // ------------------------------------------------------------------
    localparam logic [7:0] SFPP_ANS_ERASE_OK   = 8'h4f;
    localparam logic [7:0] SFPP_ANS_ERASE_FAIL = 8'h4c;
    localparam logic [7:0] SFPP_ANS_CONF_OK    = 8'h5d;
    localparam logic [7:0] SFPP_ANS_CONF_FAIL  = 8'h60;
    localparam logic [7:0] SFPP_ANS_PROG_OK    = 8'h50;
    localparam logic [7:0] SFPP_ANS_PROG_RXERR = 8'h58;
    localparam logic [7:0] SFPP_ANS_PROG_SUM   = 8'h51;
    localparam logic [3:0] SFPP_NIB_RXERR      = 4'h8;
    localparam logic [3:0] SFPP_NIB_PROT       = 4'h6;
    localparam logic [3:0] SFPP_NIB_NOERASE    = 4'h4;
    localparam logic [3:0] SFPP_NIB_BADCMD     = 4'h1;

    // ------------------------------------------------------------------
    // Header layout and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  SFPP_HDR_LAST   = 3'h6;  // Index of header checksum byte.
    localparam logic [7:0]  SFPP_SUM_ZERO   = 8'h00;
    localparam logic [31:0] SFPP_ADDR_RST   = 32'h0000_0000;
    localparam logic [15:0] SFPP_CNT_RST    = 16'h0000;
    localparam logic [7:0]  SFPP_BYTE_RST   = 8'h00;

    // States, Gray coded along the program path.
    typedef enum logic [3:0] {
        SFPP_S_CMD   = 4'b0000,
        SFPP_S_HDR   = 4'b0001,
        SFPP_S_DATA  = 4'b0011,
        SFPP_S_DSUM  = 4'b0010,
        SFPP_S_EKEY  = 4'b0110,
        SFPP_S_EWAIT = 4'b0111,
        SFPP_S_ECONF = 4'b0101,
        SFPP_S_PSET  = 4'b0100
    } sfpp_state_t;

endpackage

/* File: sfpp_tx.sv */
/*
 * One-byte answer holder: takes a byte from the interpreter and offers
 * it on the transmit stream until the transmitter accepts it.
 * Assumes the transmitter is on the same clock.
 */
module sfpp_tx
    import sfpp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // From interpreter
    sfpp_ans_if.snk         ans,
    // Transmit stream
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_ready
);

    logic       valid_r, valid_nxt;
    logic [7:0] data_r, data_nxt;

    // --------------------------------------------------------------
    // Holding register
    // --------------------------------------------------------------
    // A new byte is only taken when the slot is free, so nothing is
    // overwritten before the transmitter has seen it.
    always_comb begin
        valid_nxt = valid_r;
        data_nxt  = data_r;
        if (valid_r && i_tx_ready) begin
            valid_nxt = 1'b0;
        end
        if (ans.send && !valid_r) begin
            valid_nxt = 1'b1;
            data_nxt  = ans.data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            valid_r <= 1'b0;
            data_r  <= SFPP_BYTE_RST;
        end else begin
            valid_r <= valid_nxt;
            data_r  <= data_nxt;
        end
    end

    assign ans.busy   = valid_r;
    assign o_tx_valid = valid_r;
    assign o_tx_data  = data_r;

endmodule // sfpp_tx
